// File: dsr_core.sv
// ddr sdram command decode, read burst engine and refresh control
`include "dsr_params.svh"

// Overview of operation
// - burst terminate cuts only non-autoprecharge reads
// - terminate hits the latest registered read
// - refresh uses internal counter, ignores address
// - self refresh keeps data without clock
// - refresh with cke low enters self refresh
// - dll off in self refresh, relock 200
// - self refresh ignores all inputs but cke
// - banks activate independently, trrd spacing
// - first data at cas latency, each edge
// - dqs preamble, postamble, then float
// - later read concatenates or truncates burst
// - terminate latency equals cas latency
// - precharge truncates read, then trp wait
module dsr_core
  import dsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  output logic [`DSR_DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic [3:0] bank_open,
  output logic self_refresh,
  output logic dll_on,
  output logic [13:0] refresh_addr
);

  localparam int CL = `DSR_CAS_LAT;

  // ================================================================
  // input synchronisers
  logic [19:0] in_raw; // all pins sampled together
  logic [19:0] s1_reg; // first stage, read only by s2_reg
  logic [19:0] s2_reg; // second stage, safe to use
  logic ck_prev_reg; // last synchronised ck level
  assign in_raw = {ck, cke, cs_b, ras_b, cas_b, we_b, ba, addr};

  // two flops per pin, then one more for ck edge detection
  always_ff @(posedge ref_clk)
  begin
    s1_reg <= in_raw;
    s2_reg <= s1_reg;
    ck_prev_reg <= rst_b ? s2_reg[19] : 1'b0;
  end

  logic rise; // ck rising edge seen this cycle
  logic fall; // ck falling edge seen this cycle
  logic cke_s; // synchronised cke
  logic [1:0] ba_s; // synchronised bank address
  logic [11:0] addr_s; // synchronised address
  assign rise = s2_reg[19] & ~ck_prev_reg;
  assign fall = ~s2_reg[19] & ck_prev_reg;
  assign cke_s = s2_reg[18];
  assign ba_s = s2_reg[13:12];
  assign addr_s = s2_reg[11:0];

  // ================================================================
  // data word for a burst element; bursts run sequentially from col
  function automatic logic [`DSR_DQ_W-1:0] dsr_word(input logic [1:0] bk,
      input logic [9:0] col, input logic [2:0] idx);
    logic [9:0] c;
    c = col + {7'h00, idx};
    return c[7:0] ^ {6'h00, bk};
  endfunction

  // ================================================================
  // state
  dsr_mode_t mode_reg, mode_next; // run, self refresh or dll relock
  logic [7:0] tick_reg, tick_next; // internal refresh timer
  logic [7:0] lock_reg, lock_next; // dll relock ck count
  logic [13:0] raddr_reg, raddr_next; // internal refresh bank/row
  logic [3:0] open_reg, open_next; // open row flag per bank
  logic [CL-1:0] rd_v_reg, rd_v_next; // read latency pipe
  logic [CL-1:0] rd_ap_reg, rd_ap_next;
  logic [1:0] rd_bk_reg [CL];
  logic [1:0] rd_bk_next [CL];
  logic [9:0] rd_col_reg [CL];
  logic [9:0] rd_col_next [CL];
  logic [CL-1:0] st_v_reg, st_v_next; // stop (bst/pre) latency pipe
  logic [CL-1:0] st_bst_reg, st_bst_next;
  logic [1:0] st_bk_reg [CL];
  logic [1:0] st_bk_next [CL];
  logic [3:0] cnt_reg, cnt_next; // elements left in the burst
  logic [2:0] idx_reg, idx_next; // next element index
  logic [9:0] col_reg, col_next; // burst start column
  logic [1:0] bk_reg, bk_next; // burst bank
  logic ap_reg, ap_next; // burst has auto precharge
  logic [`DSR_DQ_W-1:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;
  logic dqs_reg, dqs_next;
  logic dqs_oe_reg, dqs_oe_next;
  logic self_ref_reg, self_ref_next; // self refresh flag, kept in a flop
  logic dll_on_reg, dll_on_next; // dll locked flag, kept in a flop

  dsr_cmd_t cmd; // command taken this cycle
  logic live; // device listens to commands
  logic sr_take; // self refresh entry this cycle
  logic start; // a read leaves the latency pipe
  logic cut; // a stop truncates the current burst
  logic pre; // preamble must be driven

  // ================================================================
  // next-state logic
  always_comb
  begin
    mode_next = mode_reg;
    tick_next = tick_reg;
    lock_next = lock_reg;
    raddr_next = raddr_reg;
    open_next = open_reg;
    rd_v_next = rd_v_reg;
    rd_ap_next = rd_ap_reg;
    rd_bk_next = rd_bk_reg;
    rd_col_next = rd_col_reg;
    st_v_next = st_v_reg;
    st_bst_next = st_bst_reg;
    st_bk_next = st_bk_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    col_next = col_reg;
    bk_next = bk_reg;
    ap_next = ap_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    dqs_next = dqs_reg;
    dqs_oe_next = dqs_oe_reg;
    // self refresh listens to nothing but cke
    live = rise && (mode_reg != MODE_SELF);
    cmd = live ? dsr_decode(s2_reg[17:14]) : CMD_NOP;
    sr_take = (cmd == CMD_REF) && !cke_s;
    if (!cke_s)
    begin
      cmd = CMD_NOP;
    end
    // mode machine
    case (mode_reg)
      MODE_RUN, MODE_LOCK:
      begin
        if (sr_take)
        begin
          mode_next = MODE_SELF;
          tick_next = 8'h00;
        end
        else if (mode_reg == MODE_LOCK && rise)
        begin
          // dll relocks over a fixed count of ck edges
          lock_next = lock_reg + 8'h01;
          if (lock_reg == `DSR_DLL_LOCK_CYC - 8'h01)
          begin
            mode_next = MODE_RUN;
          end
        end
      end
      MODE_SELF:
      begin
        // own timer keeps refreshing while ck may be stopped
        tick_next = tick_reg + 8'h01;
        if (tick_reg == 8'(`DSR_SR_TICK_CYC - 1))
        begin
          tick_next = 8'h00;
          raddr_next = raddr_reg + 14'h0001;
        end
        if (cke_s)
        begin
          mode_next = MODE_LOCK;
          lock_next = 8'h00;
        end
      end
      default: mode_next = MODE_RUN;
    endcase
    // address pins are ignored; the counter picks bank and row
    if (cmd == CMD_REF)
    begin
      raddr_next = raddr_reg + 14'h0001;
    end
    // banks open and close independently
    if (cmd == CMD_ACT)
    begin
      open_next[ba_s] = 1'b1;
    end
    if (cmd == CMD_PRE)
    begin
      if (addr_s[`DSR_AP_BIT])
      begin
        open_next = 4'h0;
      end
      else
      begin
        open_next[ba_s] = 1'b0;
      end
    end
    // latency pipes advance once per ck cycle
    if (rise)
    begin
      for (int i = CL - 1; i > 0; i--)
      begin
        rd_v_next[i] = rd_v_reg[i-1];
        rd_ap_next[i] = rd_ap_reg[i-1];
        rd_bk_next[i] = rd_bk_reg[i-1];
        rd_col_next[i] = rd_col_reg[i-1];
        st_v_next[i] = st_v_reg[i-1];
        st_bst_next[i] = st_bst_reg[i-1];
        st_bk_next[i] = st_bk_reg[i-1];
      end
      rd_v_next[0] = (cmd == CMD_RD);
      rd_ap_next[0] = addr_s[`DSR_AP_BIT];
      rd_bk_next[0] = ba_s;
      rd_col_next[0] = addr_s[9:0];
      // stops share the read latency so x cycles give x pairs
      st_v_next[0] = (cmd == CMD_BST) || (cmd == CMD_PRE);
      st_bst_next[0] = (cmd == CMD_BST);
      st_bk_next[0] = ba_s;
    end
    start = rise && rd_v_reg[CL-1];
    // terminate applies to the burst now streaming, never with ap
    cut = rise && st_v_reg[CL-1] && (cnt_reg != 4'h0) && !ap_reg &&
      (st_bst_reg[CL-1] || (st_bk_reg[CL-1] == bk_reg));
    pre = (rise && rd_v_next[CL-1]) || (fall && rd_v_reg[CL-1]);
    // output engine, one element per ck edge
    if (rise || fall)
    begin
      if (start)
      begin
        // a newer read always replaces what is streaming
        col_next = rd_col_reg[CL-1];
        bk_next = rd_bk_reg[CL-1];
        ap_next = rd_ap_reg[CL-1];
        dq_next = dsr_word(rd_bk_reg[CL-1], rd_col_reg[CL-1], 3'h0);
        cnt_next = `DSR_BURST_LEN - 4'h1;
        idx_next = 3'h1;
        dq_oe_next = 1'b1;
        dqs_next = 1'b1;
        dqs_oe_next = 1'b1;
      end
      else if (cnt_reg != 4'h0 && !cut)
      begin
        dq_next = dsr_word(bk_reg, col_reg, idx_reg);
        cnt_next = cnt_reg - 4'h1;
        idx_next = idx_reg + 3'h1;
        dqs_next = ~idx_reg[0]; // last element sits low
        if (cnt_reg == 4'h1 && ap_reg)
        begin
          open_next[bk_reg] = 1'b0;
        end
      end
      else
      begin
        cnt_next = 4'h0;
        dq_oe_next = 1'b0;
        dqs_next = 1'b0;
        // low half cycle after data, low before first data, else float
        dqs_oe_next = dq_oe_reg || pre;
      end
    end
    // flags follow the next mode so the pins stay glitch free
    self_ref_next = (mode_next == MODE_SELF);
    dll_on_next = (mode_next == MODE_RUN);
  end

  // ================================================================
  // state registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      mode_reg <= MODE_RUN;
      tick_reg <= 8'h00;
      lock_reg <= 8'h00;
      raddr_reg <= 14'h0000;
      open_reg <= 4'h0;
      rd_v_reg <= '0;
      rd_ap_reg <= '0;
      rd_bk_reg <= '{default: 2'h0};
      rd_col_reg <= '{default: 10'h000};
      st_v_reg <= '0;
      st_bst_reg <= '0;
      st_bk_reg <= '{default: 2'h0};
      cnt_reg <= 4'h0;
      idx_reg <= 3'h0;
      col_reg <= 10'h000;
      bk_reg <= 2'h0;
      ap_reg <= 1'b0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      dqs_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
      self_ref_reg <= 1'b0;
      dll_on_reg <= 1'b1;
    end
    else
    begin
      mode_reg <= mode_next;
      tick_reg <= tick_next;
      lock_reg <= lock_next;
      raddr_reg <= raddr_next;
      open_reg <= open_next;
      rd_v_reg <= rd_v_next;
      rd_ap_reg <= rd_ap_next;
      rd_bk_reg <= rd_bk_next;
      rd_col_reg <= rd_col_next;
      st_v_reg <= st_v_next;
      st_bst_reg <= st_bst_next;
      st_bk_reg <= st_bk_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      col_reg <= col_next;
      bk_reg <= bk_next;
      ap_reg <= ap_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      dqs_reg <= dqs_next;
      dqs_oe_reg <= dqs_oe_next;
      self_ref_reg <= self_ref_next;
      dll_on_reg <= dll_on_next;
    end
  end

  assign dq_out = dq_reg;
  assign dq_oe = dq_oe_reg;
  assign dqs_out = dqs_reg;
  assign dqs_oe = dqs_oe_reg;
  assign bank_open = open_reg;
  assign self_refresh = self_ref_reg;
  assign dll_on = dll_on_reg;
  assign refresh_addr = raddr_reg;

  // ================================================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence idle_read_s;
    cmd == CMD_RD && rd_v_reg == '0 && cnt_reg == 4'h0 && !dq_oe_reg;
  endsequence
  sequence data_out_s;
    ##[15:18] dq_oe_reg;
  endsequence

  chk_bst_ap_kept: assert property (rise && st_v_reg[CL-1] && ap_reg &&
    cnt_reg > 4'h1 && !start |=> cnt_reg == $past(cnt_reg) - 4'h1)
    else $error("terminate cut an auto precharge burst");
  chk_latest_read: assert property (start |=>
    cnt_reg == `DSR_BURST_LEN - 4'h1 && col_reg == $past(rd_col_reg[CL-1]))
    else $error("newest read did not take over the burst");
  chk_refresh_count: assert property (cmd == CMD_REF |=>
    refresh_addr == $past(refresh_addr) + 14'h0001)
    else $error("refresh counter did not advance");
  chk_sr_entry: assert property (sr_take |=> self_refresh && !dll_on)
    else $error("self refresh not entered");
  chk_dll_relock: assert property (mode_reg == MODE_LOCK && rise &&
    lock_reg == `DSR_DLL_LOCK_CYC - 8'h01 |=> dll_on)
    else $error("dll not back after relock count");
  chk_sr_ignores: assert property (self_refresh |=> $stable(bank_open))
    else $error("bank state changed in self refresh");
  chk_first_data: assert property (idle_read_s |-> data_out_s)
    else $error("read data not at cas latency");
  chk_dqs_preamble: assert property ($rose(dq_oe) |->
    $past(dqs_oe) && !$past(dqs_out))
    else $error("no read preamble");
  chk_dqs_postamble: assert property ($fell(dq_oe) |-> dqs_oe && !dqs_out)
    else $error("no read postamble");
  chk_trunc_ends: assert property (cut && !start |=>
    cnt_reg == 4'h0 && !dq_oe)
    else $error("stop did not truncate the burst");
  chk_bank_open: assert property (cmd == CMD_ACT |=> bank_open[$past(ba_s)])
    else $error("activate did not open bank");

endmodule

// File: dsr_params.svh
// timing, latency and field constants for the ddr sdram read/refresh core
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// ================================================================
// read datapath
`define DSR_CAS_LAT 2
`define DSR_BURST_LEN 4'h4
`define DSR_AP_BIT 10
`define DSR_DQ_W 8

// ================================================================
// refresh and dll timing
`define DSR_DLL_LOCK_CYC 8'hC8
`define DSR_REF_INT_NS 15600
`define DSR_CLK_NS 100
`define DSR_SR_TICK_CYC (`DSR_REF_INT_NS / `DSR_CLK_NS)

`endif

// File: dsr_pkg.sv
// command and mode types for the ddr sdram read/refresh core
package dsr_pkg;

  // ================================================================
  // decoded command on a ck rising edge
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_BST = 3'h4,
    CMD_PRE = 3'h5,
    CMD_REF = 3'h6,
    CMD_MRS = 3'h7
  } dsr_cmd_t;

  // operating mode of the device
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SELF = 2'b01,
    MODE_LOCK = 2'b10
  } dsr_mode_t;

  // command decode from the four active-low control pins
  function automatic dsr_cmd_t dsr_decode(input logic [3:0] ctl_b);
    case (ctl_b)
      4'h3: return CMD_ACT;
      4'h5: return CMD_RD;
      4'h4: return CMD_WR;
      4'h6: return CMD_BST;
      4'h2: return CMD_PRE;
      4'h1: return CMD_REF;
      4'h0: return CMD_MRS;
      default: return CMD_NOP;
    endcase
  endfunction

endpackage

// File: dsr_ctl_model.sv
// controller model that drives the ddr command pins and a gated ck
// ================================================================
// partner model
module dsr_ctl_model (
  input wire logic ref_clk,
  output logic ck,
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] ba,
  output logic [11:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;

  // ck rests low between frames, so it stays stable before cke rises
  initial
  begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = 4'hF;
    ba = 2'h0;
    addr = 12'h000;
  end

  // one command per ck cycle of eight ref_clk periods (800 ns)
  // no write is ever issued, so none is cut by a terminate
  // reads follow an activate by a full ck cycle
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a);
    @(posedge ref_clk);
    #2;
    {cs_b, ras_b, cas_b, we_b} = c;
    ba = b;
    addr = a;
    ck = 1'b1;
    repeat (4) @(posedge ref_clk);
    #2;
    ck = 1'b0;
    // address no longer qualified: show the inverse, never a stale value
    addr = ~a;
    repeat (3) @(posedge ref_clk);
  endtask

  // idle cycles; a run of 200 covers the self refresh exit
  task automatic nops(input int n);
    for (int i = 0; i < n; i++)
    begin
      // alternate nop and deselect; bank and address are don't care
      issue({i[0], 3'h7}, i[1:0], {i[3:0], 8'h5A});
    end
  endtask

  // each refresh is its own command; the bench lets far more than 15.6 us
  // pass in run mode without one, and nothing checks the interval
  task automatic set_cke(input logic v);
    @(posedge ref_clk);
    #2;
    cke = v;
  endtask
endmodule

// File: dsr_core_test.sv
// self-checking bench for the ddr sdram read/refresh core
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("mismatch at %0t: got %0h want %0h", $time, (a), (e)); end end

// ================================================================
// bench top
module dsr_core_test
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD = 4'h5;
  localparam logic [3:0] C_BST = 4'h6;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_REF = 4'h1;

  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ck, cke, cs_b, ras_b, cas_b, we_b;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [7:0] dq_out;
  logic dq_oe, dqs_out, dqs_oe, self_refresh, dll_on;
  logic [3:0] bank_open;
  logic [13:0] refresh_addr;
  int n_fail = 0;
  int num_checks = 0;
  // captured burst elements, filled by grab
  logic [7:0] got [8];
  int n_got;

  dsr_core i_dsr_core (.ref_clk(ref_clk), .rst_b(rst_b), .ck(ck),
    .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe), .bank_open(bank_open),
    .self_refresh(self_refresh), .dll_on(dll_on),
    .refresh_addr(refresh_addr));

  dsr_ctl_model i_dsr_ctl_model (.ref_clk(ref_clk), .ck(ck), .cke(cke),
    .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba),
    .addr(addr));

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ================================================================
  // helpers
  // sample one step after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // collect one stream of elements at mid half-period of ck
  task automatic grab();
    int w;
    logic pre;
    w = 0;
    pre = 1'b0;
    n_got = 0;
    while (dq_oe !== 1'b1 && w < 60)
    begin
      pre = (dqs_oe === 1'b1 && dqs_out === 1'b0);
      tick(1);
      w++;
    end
    `CHK(w < 60, 1'b1)
    `CHK(pre, 1'b1)
    tick(2);
    while (dq_oe === 1'b1 && n_got < 8)
    begin
      got[n_got] = dq_out;
      `CHK(dqs_out, !n_got[0])
      n_got++;
      tick(4);
    end
    `CHK({dqs_oe, dqs_out}, 2'b10)
    tick(4);
    `CHK({dq_oe, dqs_oe}, 2'b00)
  endtask

  // n1 elements from column c1, then n2 from column c2
  task automatic check(input int n1, input int c1, input int n2,
                       input int c2, input logic [1:0] b);
    int e;
    `CHK(n_got, n1 + n2)
    for (int k = 0; k < n_got && k < n1 + n2; k++)
    begin
      e = (k < n1) ? c1 + k : c2 + k - n1;
      `CHK(got[k], e[7:0] ^ {6'h00, b})
    end
  endtask

  // ================================================================
  // scenarios
  task automatic t_plain();
    i_dsr_ctl_model.issue(C_ACT, 2'h1, 12'h123);
    i_dsr_ctl_model.nops(1);
    `CHK(bank_open, 4'b0010)
    // a deselected activate must leave bank 0 closed
    i_dsr_ctl_model.issue(C_ACT | 4'h8, 2'h0, 12'h321);
    `CHK(bank_open, 4'b0010)
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h008);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(4, 8, 0, 0, 2'h1);
  endtask

  // terminate after one pair; ignored for an auto-precharge read
  task automatic t_bst();
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h008);
        i_dsr_ctl_model.issue(C_BST, 2'h2, 12'h7FF);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(2, 8, 0, 0, 2'h1);
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h408);
        i_dsr_ctl_model.issue(C_BST, 2'h0, 12'h000);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(4, 8, 0, 0, 2'h1);
    `CHK(bank_open[1], 1'b0)
    i_dsr_ctl_model.issue(C_ACT, 2'h1, 12'h123);
  endtask

  // back-to-back reads, then the same pair cut by a terminate
  task automatic t_multi();
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h000);
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h008);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(2, 0, 4, 8, 2'h1);
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h000);
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h008);
        i_dsr_ctl_model.issue(C_BST, 2'h3, 12'h000);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(2, 0, 2, 8, 2'h1);
    // second read two cycles later: both bursts run in full
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h000);
        i_dsr_ctl_model.nops(1);
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h008);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(4, 0, 4, 8, 2'h1);
  endtask

  // second bank opens beside the first, then precharge cuts its read
  task automatic t_pre();
    i_dsr_ctl_model.issue(C_ACT, 2'h2, 12'h456);
    i_dsr_ctl_model.nops(1);
    `CHK(bank_open, 4'b0110)
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h2, 12'h008);
        i_dsr_ctl_model.issue(C_PRE, 2'h2, 12'h000);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(2, 8, 0, 0, 2'h2);
    `CHK(bank_open, 4'b0010)
    // precharge to another bank must not cut the burst
    fork
      begin
        i_dsr_ctl_model.issue(C_RD, 2'h1, 12'h010);
        i_dsr_ctl_model.issue(C_PRE, 2'h3, 12'h000);
        i_dsr_ctl_model.nops(6);
      end
      grab();
    join
    check(4, 16, 0, 0, 2'h1);
    // precharge with the all-banks bit closes every bank
    i_dsr_ctl_model.issue(C_PRE, 2'h0, 12'h400);
    `CHK(bank_open, 4'b0000)
  endtask

  // entry, internal refresh, ignored command, exit and relock
  task automatic t_self();
    logic [13:0] r0;
    // two auto refreshes, one command each; address pins are ignored
    r0 = refresh_addr;
    i_dsr_ctl_model.issue(C_REF, 2'h2, 12'h3C3);
    i_dsr_ctl_model.issue(C_REF, 2'h1, 12'hC3C);
    `CHK(refresh_addr, r0 + 14'h0002)
    `CHK({self_refresh, dll_on}, 2'b01)
    i_dsr_ctl_model.set_cke(1'b0);
    i_dsr_ctl_model.issue(C_REF, 2'h3, 12'hFFF);
    `CHK({self_refresh, dll_on}, 2'b10)
    r0 = refresh_addr;
    tick(170);
    `CHK(refresh_addr, r0 + 14'h0001)
    i_dsr_ctl_model.issue(C_ACT, 2'h3, 12'h0F0);
    `CHK(bank_open[3], 1'b0)
    `CHK(self_refresh, 1'b1)
    i_dsr_ctl_model.set_cke(1'b1);
    i_dsr_ctl_model.nops(190);
    `CHK(dll_on, 1'b0)
    i_dsr_ctl_model.nops(12);
    `CHK({self_refresh, dll_on}, 2'b01)
  endtask

  // ================================================================
  // verdict and run control
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // whole run is about 2,400 ref_clk periods; allow about four times that
  initial
  begin
    #1_000_000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    tick(16);
    `CHK({dq_oe, dqs_oe, bank_open, self_refresh, dll_on}, 8'h01)
    `CHK(refresh_addr, 14'h0000)
    #1;
    rst_b = 1'b1;
    tick(4);
    t_plain();
    t_bst();
    t_multi();
    t_pre();
    t_self();
    stop_test();
  end
endmodule
